/* rtl/tee_cfg.svh */
// Constants for the tracking-enable edge detect front end
`ifndef TEE_CFG_SVH
`define TEE_CFG_SVH
`define TEE_NUM_CH      3
`define TEE_CNT_W       32
`define TEE_CNT_RST     32'h0000_0000
`define TEE_SYNC_RST    2'h0
`define TEE_IND_RST     1'h0
`endif

/* rtl/tee_pkg.sv */
// Types for the tracking-enable edge detect front end
`include "tee_cfg.svh"
package tee_pkg;
   // One raw channel of the pulse input connector
   typedef struct packed {
      logic phase_a;
      logic phase_b;
      logic trig;
   } tee_pins_type;
   // Edge-select switch pair of one channel
   typedef struct packed {
      logic sel_a;
      logic sel_b;
   } tee_sel_type;
   typedef enum logic [1:0] {TEE_DISABLED, TEE_RUNNING} tee_mode_type;
endpackage

/* rtl/tee_chan.sv */
// One encoder plus tracking-enable channel: sync, x4 count, edge capture
`timescale 1ns/100ps
`default_nettype none
`include "tee_cfg.svh"
module tee_chan (
   // Clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     nrst,
   // Control
   input  wire logic                     enable,
   input  wire tee_pkg::tee_sel_type     sel,
   // Pins
   input  wire tee_pkg::tee_pins_type    pins,
   // Results
   output logic                          ind_a,
   output logic                          ind_b,
   output logic                          ind_trig,
   output logic                          event_pulse,
   output logic [`TEE_CNT_W-1:0]         count,
   output logic [`TEE_CNT_W-1:0]         latched_encoder_count
);
   typedef struct packed {
      logic [1:0]            sa;
      logic [1:0]            sb;
      logic [1:0]            st;
      logic                  pa;
      logic                  pb;
      logic                  pt;
      logic                  ev;
      logic                  pe;
      logic [`TEE_CNT_W-1:0] cnt;
      logic [`TEE_CNT_W-1:0] hold;
   } tee_chan_state_type;

   tee_chan_state_type st, next_st;
   logic lead_mode;
   logic qa;
   logic qb;
   logic qt;
   logic step;
   logic up;
   logic hit;

   // ====================
   // Next state
   always_comb begin
      next_st = st;
      next_st.sa = {st.sa[0], pins.phase_a};
      next_st.sb = {st.sb[0], pins.phase_b};
      next_st.st = {st.st[0], pins.trig};
      qa = st.sa[1] & enable;
      qb = st.sb[1] & enable;
      qt = st.st[1] & enable;
      next_st.pa = qa;
      next_st.pb = qb;
      next_st.pt = qt;
      next_st.pe = enable;
      // x4 decode: any edge of A or B is one step
      step = (qa ^ st.pa) | (qb ^ st.pb);
      up   = qa ^ st.pb;
      // gating edges on enable change are not phase steps
      if (enable && st.pe && step && !((qa ^ st.pa) && (qb ^ st.pb))) begin
         next_st.cnt = up ? st.cnt + 1'b1 : st.cnt - 1'b1;
      end
      // equal switches pick leading edge, differing pick trailing
      lead_mode = ~(sel.sel_a ^ sel.sel_b);
      hit = lead_mode ? (qt & ~st.pt) : (~qt & st.pt);
      next_st.ev = hit;
      if (hit) begin
         next_st.hold = st.cnt;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign ind_a                 = st.pa;
   assign ind_b                 = st.pb;
   assign ind_trig              = st.pt;
   assign event_pulse           = st.ev;
   assign count                 = st.cnt;
   assign latched_encoder_count = st.hold;

   // ====================
   // Checks
   // indicators dark while disabled
   ind_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $past(!enable) |-> !ind_trig && !ind_a && !ind_b)
      else $error("indicator on while disabled");
   lead_evt_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ($past(sel.sel_a == sel.sel_b) && ind_trig && !$past(ind_trig)) |-> event_pulse)
      else $error("leading edge missed");
   trail_evt_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ($past(sel.sel_a != sel.sel_b) && !ind_trig && $past(ind_trig)) |-> event_pulse)
      else $error("trailing edge missed");
   cap_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      event_pulse |-> latched_encoder_count == $past(count))
      else $error("capture mismatch");
   cnt_step_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (count != $past(count)) |-> (count - $past(count) == 32'h0000_0001
         || $past(count) - count == 32'h0000_0001))
      else $error("count jumped");
   sync_lat_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ($past(enable) && $past(enable, 2) && $past(enable, 3)) |-> ind_a == $past(pins.phase_a, 3))
      else $error("sync latency wrong");
   evt_c: cover property (@(posedge clk_sys) disable iff (!nrst) event_pulse);
   up_c: cover property (@(posedge clk_sys) disable iff (!nrst) count == $past(count) + 1'b1);
   dn_c: cover property (@(posedge clk_sys) disable iff (!nrst) count == $past(count) - 1'b1);
endmodule
`default_nettype wire

/* rtl/tee_top.sv */
// Three-channel tracking-enable and encoder input front end
`timescale 1ns/100ps
`default_nettype none
`include "tee_cfg.svh"
// What this block does
// - Drive phase A and B indicators for encoder channels one to three.
// - Drive one tracking-trigger indicator per channel, showing its present state.
// - While not enabled, all inputs and indicators read inactive.
// - Each channel has its own two-switch edge-select pair.
// - Equal switches: event on leading edge of the trigger.
// - Differing switches: event on trailing edge of the trigger.
// - Factory default switches off, so leading edge detection.
// - On each event, capture encoder count into a readable holding value.
// - Count phases A and B times four, every edge of either, except when A and B both change in one cycle.
module tee_top (
   // Clock and reset
   input  wire logic                         clk_sys,
   input  wire logic                         nrst,
   // System configuration
   input  wire logic                         module_enable,
   input  wire logic                         edge_sel_a_ch1,
   input  wire logic                         edge_sel_b_ch1,
   input  wire logic                         edge_sel_a_ch2,
   input  wire logic                         edge_sel_b_ch2,
   input  wire logic                         edge_sel_a_ch3,
   input  wire logic                         edge_sel_b_ch3,
   // Connector inputs
   input  wire logic [2:0]                   phase_a_in,
   input  wire logic [2:0]                   phase_b_in,
   input  wire logic                         track_trigger_in_ch1,
   input  wire logic                         track_trigger_in_ch2,
   input  wire logic                         track_trigger_in_ch3,
   // Indicators
   output logic [2:0]                        phase_a_indicator,
   output logic [2:0]                        phase_b_indicator,
   output logic [2:0]                        track_trigger_indicator,
   // Results to controller
   output logic [2:0]                        track_event,
   output logic [3*`TEE_CNT_W-1:0]           encoder_count,
   output logic [3*`TEE_CNT_W-1:0]           latched_encoder_count
);
   tee_pkg::tee_sel_type  sel  [3];
   tee_pkg::tee_pins_type pins [3];
   logic                  enabled;
   logic [2:0]            trig;

   // Configuration enable registered so every path is flop-timed
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         enabled <= 1'b0;
      end else begin
         enabled <= module_enable;
      end
   end

   always_comb begin
      sel[0] = '{sel_a: edge_sel_a_ch1, sel_b: edge_sel_b_ch1};
      sel[1] = '{sel_a: edge_sel_a_ch2, sel_b: edge_sel_b_ch2};
      sel[2] = '{sel_a: edge_sel_a_ch3, sel_b: edge_sel_b_ch3};
   end
   assign trig = {track_trigger_in_ch3, track_trigger_in_ch2, track_trigger_in_ch1};

   for (genvar i = 0; i < `TEE_NUM_CH; i++) begin : g_ch
      assign pins[i] = '{phase_a: phase_a_in[i], phase_b: phase_b_in[i], trig: trig[i]};
      tee_chan u_chan (
         .clk_sys               (clk_sys),
         .nrst                  (nrst),
         .enable                (enabled),
         .sel                   (sel[i]),
         .pins                  (pins[i]),
         .ind_a                 (phase_a_indicator[i]),
         .ind_b                 (phase_b_indicator[i]),
         .ind_trig              (track_trigger_indicator[i]),
         .event_pulse           (track_event[i]),
         .count                 (encoder_count[i*`TEE_CNT_W +: `TEE_CNT_W]),
         .latched_encoder_count (latched_encoder_count[i*`TEE_CNT_W +: `TEE_CNT_W])
      );
   end

   // switches all off gives leading edge
   dflt_lead_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ($past(!edge_sel_a_ch1 && !edge_sel_b_ch1) && track_trigger_indicator[0]
         && !$past(track_trigger_indicator[0])) |-> track_event[0])
      else $error("default leading edge missed");
   no_evt_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (!enabled && !$past(enabled) && !$past(enabled, 2)) |-> track_event == 3'h0)
      else $error("event while disabled");

   // ====================
   // Per-channel checks
   for (genvar j = 0; j < `TEE_NUM_CH; j++) begin : g_chk
      pha_ind_a: assert property (@(posedge clk_sys) disable iff (!nrst)
         ($past(enabled) && $past(enabled, 2) && $past(enabled, 3))
         |-> phase_a_indicator[j] == $past(phase_a_in[j], 3))
         else $error("phase A indicator wrong");
      phb_ind_a: assert property (@(posedge clk_sys) disable iff (!nrst)
         ($past(enabled) && $past(enabled, 2) && $past(enabled, 3))
         |-> phase_b_indicator[j] == $past(phase_b_in[j], 3))
         else $error("phase B indicator wrong");
      trig_ind_a: assert property (@(posedge clk_sys) disable iff (!nrst)
         ($past(enabled) && $past(enabled, 2) && $past(enabled, 3))
         |-> track_trigger_indicator[j] == $past(trig[j], 3))
         else $error("trigger indicator wrong");
      cnt_frozen_a: assert property (@(posedge clk_sys) disable iff (!nrst)
         (!$past(enabled) || !$past(enabled, 2))
         |-> encoder_count[j*`TEE_CNT_W +: `TEE_CNT_W]
            == $past(encoder_count[j*`TEE_CNT_W +: `TEE_CNT_W]))
         else $error("count moved while disabled");
      pair_edge_a: assert property (@(posedge clk_sys) disable iff (!nrst)
         track_event[j] == ($past(sel[j].sel_a == sel[j].sel_b)
            ? $rose(track_trigger_indicator[j]) : $fell(track_trigger_indicator[j])))
         else $error("event does not match edge select");
   end

   en_c: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(enabled));
   all_c: cover property (@(posedge clk_sys) disable iff (!nrst) &track_event);
endmodule
`default_nettype wire

/* verif/tee_partner.sv */
// Photoelectric sensor and quadrature encoder model for the pulse connector
`timescale 1ns/100ps
`default_nettype none
module tee_partner (
   // Clock and bench control
   input  wire logic       clk_sys,
   input  wire logic       step,
   input  wire logic       up,
   input  wire logic [2:0] trig_lvl,
   // Connector side
   output logic [2:0]      phase_a,
   output logic [2:0]      phase_b,
   output logic [2:0]      trig
);
   // ====================
   // Encoder phases
   logic [1:0] ph = 2'h0;
   // All three encoders move in lockstep; A leads B when counting up
   always @(posedge clk_sys) if (step) ph <= up ? ph + 2'h1 : ph - 2'h1;
   assign phase_a = {3{ph[0] ^ ph[1]}};
   assign phase_b = {3{ph[1]}};
   assign trig = trig_lvl;
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the tracking-enable front end
`timescale 1ns/100ps
`default_nettype none
`include "tee_cfg.svh"
module testbench;
   logic                     clk_sys = 1'b0;
   logic                     nrst = 1'b0;
   logic                     module_enable = 1'b0;
   logic [5:0]               sel = 6'h00;
   logic                     step = 1'b0;
   logic                     up = 1'b1;
   logic [2:0]               trig_lvl = 3'h0;
   logic [2:0]               pa, pb, trig, ind_a, ind_b, ind_t, track_event, lead;
   logic [3*`TEE_CNT_W-1:0]  cnt, lat;
   logic [2:0]               exp_q[$];
   int                       num_errors = 0;
   int                       compares = 0;
   int                       seed = 98865;

   always #2 clk_sys = ~clk_sys;

   tee_top i_dut (.clk_sys(clk_sys), .nrst(nrst), .module_enable(module_enable),
      .edge_sel_a_ch1(sel[0]), .edge_sel_b_ch1(sel[1]), .edge_sel_a_ch2(sel[2]),
      .edge_sel_b_ch2(sel[3]), .edge_sel_a_ch3(sel[4]), .edge_sel_b_ch3(sel[5]),
      .phase_a_in(pa), .phase_b_in(pb), .track_trigger_in_ch1(trig[0]),
      .track_trigger_in_ch2(trig[1]), .track_trigger_in_ch3(trig[2]),
      .phase_a_indicator(ind_a), .phase_b_indicator(ind_b),
      .track_trigger_indicator(ind_t), .track_event(track_event),
      .encoder_count(cnt), .latched_encoder_count(lat));

   tee_partner i_partner (.clk_sys(clk_sys), .step(step), .up(up), .trig_lvl(trig_lvl),
      .phase_a(pa), .phase_b(pb), .trig(trig));

   // ====================
   // Shared tasks
   task automatic check(input string name, input logic [95:0] exp, input logic [95:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic enc(input int n, input logic dir);
      up = dir;
      repeat (n) begin
         step = 1'b1;
         cyc(1);
         step = 1'b0;
         cyc(3);
      end
   endtask
   task automatic finish_test;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic drain;
      // Trigger must be seen low before the next switch change
      for (int i = 0; i < 20 && (exp_q.size() != 0 || ind_t != 3'h0); i++) cyc(1);
      if (exp_q.size() != 0 || ind_t != 3'h0) begin
         num_errors++;
         $display("ERROR pending events expected 0 seen %0d", exp_q.size());
         finish_test();
      end
   endtask

   // Every event pulse takes the oldest note
   always @(negedge clk_sys) if (nrst && track_event !== 3'h0) begin
      if (exp_q.size() == 0) check("unexpected event", 96'h0, track_event);
      else check("track_event", exp_q.pop_front(), track_event);
   end

   // ====================
   // Main sequence
   initial begin
      cyc(2);
      nrst = 1'b1;
      trig_lvl = 3'h7;
      enc(2, 1'b1);
      check("indicators off", 9'h000, {ind_a, ind_b, ind_t});
      enc(2, 1'b1);
      trig_lvl = 3'h0;
      cyc(5);
      check("count off", 96'h0, cnt);
      $display("test disabled done");
      module_enable = 1'b1;
      cyc(2);
      enc(8, 1'b1);
      enc(3, 1'b0);
      cyc(3);
      check("encoder_count", {3{32'h0000_0005}}, cnt);
      check("phase indicators", 6'h38, {ind_a, ind_b});
      module_enable = 1'b0;
      cyc(4);
      check("indicators disabled", 9'h000, {ind_a, ind_b, ind_t});
      check("count disabled", {3{32'h0000_0005}}, cnt);
      module_enable = 1'b1;
      cyc(4);
      check("count across enable", {3{32'h0000_0005}}, cnt);
      enc(1, 1'b1);
      cyc(3);
      check("phase B indicators", 6'h3f, {ind_a, ind_b});
      check("encoder_count", {3{32'h0000_0006}}, cnt);
      $display("test count done");
      for (int k = 0; k < 8; k++) begin
         sel = (k == 0) ? 6'h00 : 6'($random(seed));
         lead = ~{sel[5] ^ sel[4], sel[3] ^ sel[2], sel[1] ^ sel[0]};
         cyc(2);
         trig_lvl = 3'h7;
         if (lead != 3'h0) exp_q.push_back(lead);
         cyc(2);
         check("trigger sync delay", 3'h0, ind_t);
         cyc(3);
         check("trigger indicators", 3'h7, ind_t);
         trig_lvl = 3'h0;
         if (lead != 3'h7) exp_q.push_back(~lead);
         drain();
      end
      check("latched count", {3{32'h0000_0006}}, lat);
      $display("test edges done");
      finish_test();
   end
endmodule
`default_nettype wire
